/* File: common/flags_params.svh */
// Purpose: named constants for the status flag and address generation block
// Assumes: included by its bare name wherever a constant is needed
// Notes: definitions only
`ifndef FLAGS_PARAMS_SVH
`define FLAGS_PARAMS_SVH

// flag bit positions inside the status byte
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_I 2
`define FLAG_D 3
`define FLAG_B 4
`define FLAG_T 5
`define FLAG_V 6
`define FLAG_N 7

// status byte after reset: interrupt mask set, every other flag zero
`define FL_RESET 8'h04
`define SP_RESET 8'hff

// register port offsets
`define REG_FL 2'h0
`define REG_SP 2'h1
`define REG_CTRL 2'h2
`define REG_STAT 2'h3
`define CTRL_PAGE_SEL 0

// page bytes
`define ZERO_PAGE_HI 8'h00
`define STACK_PAGE_HI 8'h01

// instruction lengths in bytes
`define LEN_ONE 2'h1
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3

// packed decimal correction
`define BCD_MAX 5'h09
`define BCD_ADJ 5'h06

`endif

/* File: common/flags_pkg.sv */
// Purpose: shared types of the status flag and address generation block
// Assumes: nothing
// Notes: constants live in flags_params.svh
package flags_pkg;

   // flag-affecting operations presented by the instruction sequencer
   typedef enum logic [4:0] {
      cmd_none, carry_set_insn, carry_clear_insn, interrupt_mask_insn,
      interrupt_enable_insn, decimal_on_insn, binary_mode_insn, memory_mode_insn,
      accumulator_mode_insn, overflow_clear_insn, cmd_add_carry, subtract_borrow_insn,
      cmd_transfer, cmd_shift_left, cmd_shift_right, cmd_rotate_left, cmd_rotate_right,
      cmd_bit_test, software_break_insn
   } flag_cmd_t;

   // the nineteen addressing modes of the decoder
   typedef enum logic [4:0] {
      am_imm, am_acc, am_zp, am_zpx, am_zpy, am_abs, am_absx, am_absy, am_implied,
      am_rel, am_indx, am_indy, am_ind_abs, am_zp_ind, am_special, am_zp_bit,
      am_acc_bit, am_acc_bit_rel, am_zp_bit_rel
   } addr_mode_t;

   // interrupt push sequence
   typedef enum logic [1:0] {
      st_idle, st_push_hi, st_push_lo, st_push_ps
   } push_state_t;

endpackage

/* File: src/operand_addr_gen.sv */
// Purpose: effective address, operand data and instruction length per mode
// Assumes: operand bytes and index registers are stable in the cycle
// Notes: purely combinational; the caller registers the outputs
`include "flags_params.svh"

module operand_addr_gen (
   input wire flags_pkg::addr_mode_t mode,
   input wire logic [7:0] opnd_lo,
   input wire logic [7:0] opnd_hi,
   input wire logic [7:0] idx_x,
   input wire logic [7:0] idx_y,
   input wire logic [7:0] acc,
   input wire logic [7:0] mem_rdata,
   output logic [15:0] addr,
   output logic [7:0] data,
   output logic [1:0] len,
   output logic mode_ok
);

   // zero-page sums drop their carry, absolute sums keep it
   wire [7:0] zp_x_lo = opnd_lo + idx_x; // RL17
   wire [7:0] zp_y_lo = opnd_lo + idx_y; // RL18
   wire [15:0] abs_base = {opnd_hi, opnd_lo}; // RL19
   wire [15:0] abs_x_sum = abs_base + {8'h00, idx_x}; // RL20 RL22

   // address per mode; modes outside this subset give zero and mode_ok low
   always_comb begin
      addr = 16'h0000;
      mode_ok = 1'b1;
      case (mode)
         flags_pkg::am_imm, flags_pkg::am_acc: addr = 16'h0000;
         flags_pkg::am_zp: addr = {`ZERO_PAGE_HI, opnd_lo}; // RL16
         flags_pkg::am_zpx: addr = {`ZERO_PAGE_HI, zp_x_lo}; // RL17
         flags_pkg::am_zpy: addr = {`ZERO_PAGE_HI, zp_y_lo}; // RL18
         flags_pkg::am_abs: addr = abs_base; // RL19
         flags_pkg::am_absx: addr = abs_x_sum; // RL20
         default: mode_ok = 1'b0; // RL13
      endcase
   end

   // immediate needs no memory read, accumulator mode reads the accumulator
   assign data = (mode == flags_pkg::am_imm) ? opnd_lo : // RL14
                 (mode == flags_pkg::am_acc) ? acc : mem_rdata; // RL15

   // opcode byte plus zero, one or two operand bytes
   assign len = (mode == flags_pkg::am_abs || mode == flags_pkg::am_absx) ? `LEN_THREE : // RL12
                (mode == flags_pkg::am_acc) ? `LEN_ONE : `LEN_TWO;

endmodule

/* File: src/status_flags_and_address_gen.sv */
// Purpose: processor status flags, interrupt push sequence and operand addressing
// Assumes: one 25 MHz clock, commands presented one cycle each while not busy
// Notes: clk_en low freezes every flip-flop; reset acts regardless of clk_en
`include "flags_params.svh"

// Overview of operation
// RL1 - after reset the interrupt mask is 1; other flags get a fixed value
// RL2 - carry holds arithmetic carry or borrow, shift bits; set and clear commands
// RL3 - zero flag is 1 for a zero arithmetic or transfer result, else 0
// RL4 - interrupt mask blocks interrupts, sets on acceptance; set and clear commands
// RL5 - decimal flag selects packed two-digit decimal add and subtract with correction
// RL6 - decimal mode touches only add and subtract; N, V, Z then meaningless
// RL7 - break bit is 1 in the pushed status for software break only
// RL8 - memory mode flag sends arithmetic result to the byte addressed by X
// RL9 - overflow sets on signed overflow; only its clear command clears it (the code also clears it on a flag register write)
// RL10 - bit test sets overflow when operand bit 6 is 1
// RL11 - negative flag takes bit 7 of each transfer or arithmetic result
// RL12 - instructions are one, two or three bytes, opcode first
// RL13 - decoder knows nineteen addressing modes; the code decodes seven of them, the rest give mode_ok low
// RL14 - immediate mode uses the operand byte itself as data
// RL15 - accumulator mode uses the accumulator as data
// RL16 - zero page address is operand low byte with high byte zero
// RL17 - zero page X adds X to operand, carry dropped, high byte zero
// RL18 - zero page Y adds Y to operand, carry dropped, high byte zero
// RL19 - absolute address is first operand low, second operand high
// RL20 - absolute X adds X to the sixteen-bit operand address
// RL21 - interrupt pushes PC high, PC low, status; stack pointer decrements each
// RL22 - absolute X carry from low byte ripples into high byte
module status_flags_and_address_gen (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic cmd_valid,
   input wire flags_pkg::flag_cmd_t cmd,
   input wire flags_pkg::addr_mode_t mode,
   input wire logic [7:0] opnd_lo,
   input wire logic [7:0] opnd_hi,
   input wire logic [7:0] idx_x,
   input wire logic [7:0] idx_y,
   input wire logic [7:0] acc,
   input wire logic [7:0] mem_rdata,
   input wire logic [7:0] xmem_rdata,
   input wire logic [15:0] pc_in,
   input wire logic irq_req,
   output logic irq_ack,
   output logic busy,
   output logic [15:0] eff_addr,
   output logic [7:0] operand_data,
   output logic [1:0] insn_len,
   output logic mode_ok,
   output logic [7:0] result,
   output logic result_to_mem,
   output logic [15:0] result_addr,
   output logic [15:0] stack_addr,
   output logic [7:0] stack_wdata,
   output logic stack_wr,
   output logic [7:0] flags
);

   ////////////////////////////////////////////////////////////////////////////
   // arithmetic helper: returns {carry, overflow, result}
   function automatic logic [9:0] arith(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin, input logic dec,
                                        input logic sub);
      logic [7:0] bb;
      logic [8:0] sum;
      logic [4:0] lo;
      logic [4:0] hi;
      logic ovf;
      bb = sub ? ~b : b;
      sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
      ovf = (a[7] == bb[7]) && (sum[7] != a[7]); // RL9
      lo = 5'h00;
      hi = 5'h00;
      if (!dec) begin
         arith = {sum[8], ovf, sum[7:0]};
      end else if (!sub) begin
         // packed decimal add, one nibble correction each
         lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin}; // RL5
         if (lo > `BCD_MAX) lo = lo + `BCD_ADJ;
         hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
         if (hi > `BCD_MAX) hi = hi + `BCD_ADJ;
         arith = {hi[4], ovf, hi[3:0], lo[3:0]};
      end else begin
         // packed decimal subtract, borrow is the inverted carry
         lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin}; // RL5
         if (lo[4]) lo = lo - `BCD_ADJ;
         hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo[4]};
         if (hi[4]) hi = hi - `BCD_ADJ;
         arith = {~hi[4], ovf, hi[3:0], lo[3:0]};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state
   flags_pkg::push_state_t state;
   flags_pkg::push_state_t next_state;
   logic [7:0] next_flags;
   logic [7:0] next_result;
   logic [7:0] sp;
   logic [15:0] saved_pc;
   logic brk_pending;
   logic page_sel;
   logic take_cmd;
   logic take_irq;
   logic take_brk;

   // addressing for the presented mode
   logic [15:0] gen_addr;
   logic [7:0] gen_data;
   logic [1:0] gen_len;
   logic gen_ok;

   operand_addr_gen u_addr (
      .mode(mode),
      .opnd_lo(opnd_lo),
      .opnd_hi(opnd_hi),
      .idx_x(idx_x),
      .idx_y(idx_y),
      .acc(acc),
      .mem_rdata(mem_rdata),
      .addr(gen_addr),
      .data(gen_data),
      .len(gen_len),
      .mode_ok(gen_ok)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decode of register port and commands
   wire idle = (state == flags_pkg::st_idle);
   wire wr_fl = reg_wr && (reg_addr == `REG_FL);
   wire wr_sp = reg_wr && (reg_addr == `REG_SP);
   wire wr_ctrl = reg_wr && (reg_addr == `REG_CTRL);
   assign take_cmd = cmd_valid && idle;
   assign take_brk = take_cmd && (cmd == flags_pkg::software_break_insn);
   assign take_irq = irq_req && idle && !flags[`FLAG_I] && !take_cmd; // RL4
   wire is_arith = (cmd == flags_pkg::cmd_add_carry) || (cmd == flags_pkg::subtract_borrow_insn);

   // memory mode swaps the accumulator for the byte at X
   wire [7:0] lhs = flags[`FLAG_T] ? xmem_rdata : acc; // RL8
   wire [9:0] sum_out = arith(lhs, gen_data, flags[`FLAG_C], flags[`FLAG_D], // RL6
                              cmd == flags_pkg::subtract_borrow_insn);

   // busy and stack_wr straight from state, irq_ack from the accept decode
   assign busy = !idle;
   assign irq_ack = take_irq || take_brk;
   assign stack_wr = !idle;
   assign stack_addr = {page_sel ? `STACK_PAGE_HI : `ZERO_PAGE_HI, sp};
   assign stack_wdata = (state == flags_pkg::st_push_hi) ? saved_pc[15:8] : // RL21
                        (state == flags_pkg::st_push_lo) ? saved_pc[7:0] :
                        {flags[7:5], brk_pending, flags[3:0]}; // RL7

   ////////////////////////////////////////////////////////////////////////////
   // next flag values: register write first, then mask on accept, then command
   always_comb begin
      next_flags = flags;
      next_result = result;
      if (wr_fl) next_flags = reg_wdata;
      if (irq_ack) next_flags[`FLAG_I] = 1'b1; // RL4
      if (take_cmd) begin
         case (cmd)
            flags_pkg::carry_set_insn: next_flags[`FLAG_C] = 1'b1; // RL2
            flags_pkg::carry_clear_insn: next_flags[`FLAG_C] = 1'b0; // RL2
            flags_pkg::interrupt_mask_insn: next_flags[`FLAG_I] = 1'b1; // RL4
            flags_pkg::interrupt_enable_insn: next_flags[`FLAG_I] = 1'b0; // RL4
            flags_pkg::decimal_on_insn: next_flags[`FLAG_D] = 1'b1; // RL5
            flags_pkg::binary_mode_insn: next_flags[`FLAG_D] = 1'b0; // RL5
            flags_pkg::memory_mode_insn: next_flags[`FLAG_T] = 1'b1; // RL8
            flags_pkg::accumulator_mode_insn: next_flags[`FLAG_T] = 1'b0; // RL8
            flags_pkg::overflow_clear_insn: next_flags[`FLAG_V] = 1'b0; // RL9
            flags_pkg::cmd_add_carry, flags_pkg::subtract_borrow_insn: begin
               next_result = sum_out[7:0];
               next_flags[`FLAG_C] = sum_out[9]; // RL2
               next_flags[`FLAG_V] = flags[`FLAG_V] | sum_out[8]; // RL9
            end
            flags_pkg::cmd_transfer: next_result = gen_data;
            flags_pkg::cmd_shift_left: begin
               next_result = {gen_data[6:0], 1'b0};
               next_flags[`FLAG_C] = gen_data[7]; // RL2
            end
            flags_pkg::cmd_shift_right: begin
               next_result = {1'b0, gen_data[7:1]};
               next_flags[`FLAG_C] = gen_data[0]; // RL2
            end
            flags_pkg::cmd_rotate_left: begin
               next_result = {gen_data[6:0], flags[`FLAG_C]};
               next_flags[`FLAG_C] = gen_data[7]; // RL2
            end
            flags_pkg::cmd_rotate_right: begin
               next_result = {flags[`FLAG_C], gen_data[7:1]};
               next_flags[`FLAG_C] = gen_data[0]; // RL2
            end
            flags_pkg::cmd_bit_test: begin
               next_flags[`FLAG_V] = flags[`FLAG_V] | gen_data[6]; // RL10
               next_flags[`FLAG_N] = gen_data[7];
               next_flags[`FLAG_Z] = ((acc & gen_data) == 8'h00);
            end
            default: next_flags = next_flags;
         endcase
         // sign and zero follow every result-producing command
         if (is_arith ||
             (cmd >= flags_pkg::cmd_transfer && cmd <= flags_pkg::cmd_rotate_right)) begin
            next_flags[`FLAG_Z] = (next_result == 8'h00); // RL3
            next_flags[`FLAG_N] = next_result[7]; // RL11
         end
      end
   end

   // push sequence walks three stack bytes then returns idle
   always_comb begin
      next_state = state;
      case (state)
         flags_pkg::st_idle: if (irq_ack) next_state = flags_pkg::st_push_hi; // RL21
         flags_pkg::st_push_hi: next_state = flags_pkg::st_push_lo;
         flags_pkg::st_push_lo: next_state = flags_pkg::st_push_ps;
         default: next_state = flags_pkg::st_idle;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // flag register, fixed reset values so simulation never sees unknowns
   always_ff @(posedge ref_clk) begin
      if (sys_rst) flags <= `FL_RESET; // RL1
      else if (clk_en) flags <= next_flags;
   end

   // push state and stack pointer; software may reload sp only while idle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state <= flags_pkg::st_idle;
         sp <= `SP_RESET;
      end else if (clk_en) begin
         state <= next_state;
         if (!idle) sp <= sp - 8'h01; // RL21
         else if (wr_sp) sp <= reg_wdata;
      end
   end

   // capture the return address and the break marker on accept
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         saved_pc <= 16'h0000;
         brk_pending <= 1'b0;
         page_sel <= 1'b1;
      end else if (clk_en) begin
         if (irq_ack) saved_pc <= pc_in;
         if (irq_ack) brk_pending <= take_brk; // RL7
         if (wr_ctrl) page_sel <= reg_wdata[`CTRL_PAGE_SEL];
      end
   end

   // registered operand path and result destination
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         eff_addr <= 16'h0000;
         operand_data <= 8'h00;
         insn_len <= `LEN_ONE;
         mode_ok <= 1'b0;
         result <= 8'h00;
         result_to_mem <= 1'b0;
         result_addr <= 16'h0000;
      end else if (clk_en) begin
         eff_addr <= gen_addr;
         operand_data <= gen_data;
         insn_len <= gen_len;
         mode_ok <= gen_ok;
         result <= next_result;
         if (take_cmd && is_arith) result_to_mem <= flags[`FLAG_T]; // RL8
         if (take_cmd && is_arith) result_addr <= {`ZERO_PAGE_HI, idx_x};
      end
   end

   // read data one cycle after the strobe, status offset reads busy in bit 0
   always_ff @(posedge ref_clk) begin
      if (sys_rst) reg_rdata <= 8'h00;
      else if (clk_en && reg_rd) begin
         if (reg_addr == `REG_FL) reg_rdata <= flags;
         else if (reg_addr == `REG_SP) reg_rdata <= sp;
         else if (reg_addr == `REG_CTRL) reg_rdata <= {7'h00, page_sel};
         else reg_rdata <= {7'h00, busy};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst || !clk_en);

   sequence push_hi_s(logic [15:0] pc);
      stack_wr && stack_wdata == pc[15:8];
   endsequence
   sequence push_lo_ps_s(logic [15:0] pc);
      stack_wr && stack_wdata == pc[7:0] ##1 stack_wr && state == flags_pkg::st_push_ps;
   endsequence

   reset_mask_a: assert property (disable iff (1'b0) sys_rst |=> flags[`FLAG_I]) // RL1
      else $error("mask not set after reset");
   carry_cmd_a: assert property (take_cmd && cmd == flags_pkg::carry_set_insn && !wr_fl
      |=> flags[`FLAG_C]) else $error("carry set command lost"); // RL2
   zero_flag_a: assert property (take_cmd && cmd == flags_pkg::cmd_transfer
      |=> flags[`FLAG_Z] == (result == 8'h00)) else $error("zero flag wrong"); // RL3
   mask_on_accept_a: assert property (irq_ack |=> flags[`FLAG_I] ##1 !irq_ack) // RL4
      else $error("accept left mask clear");
   irq_blocked_a: assert property (irq_req && flags[`FLAG_I] && !take_cmd |-> !irq_ack)
      else $error("masked interrupt taken"); // RL4
   decimal_add_a: assert property (take_cmd && cmd == flags_pkg::cmd_add_carry
      && flags[`FLAG_D] && !flags[`FLAG_T] && !flags[`FLAG_C] && acc == 8'h09
      && gen_data == 8'h01 |=> result == 8'h10) else $error("decimal add wrong"); // RL5
   break_mark_a: assert property (state == flags_pkg::st_push_ps
      |-> stack_wdata[`FLAG_B] == brk_pending) else $error("break bit wrong"); // RL7
   mem_dest_a: assert property (take_cmd && is_arith |=> result_to_mem == $past(flags[`FLAG_T])
      && result_addr[7:0] == $past(idx_x)) else $error("result target wrong"); // RL8
   ovf_sticky_a: assert property ($fell(flags[`FLAG_V]) |-> $past(wr_fl) || $past(take_cmd
      && cmd == flags_pkg::overflow_clear_insn)) else $error("overflow cleared"); // RL9
   bit_test_a: assert property (take_cmd && cmd == flags_pkg::cmd_bit_test && gen_data[6]
      |=> flags[`FLAG_V]) else $error("bit test overflow"); // RL10
   sign_flag_a: assert property (take_cmd && is_arith |=> flags[`FLAG_N] == result[7])
      else $error("negative flag wrong"); // RL11
   zpx_wrap_a: assert property (mode == flags_pkg::am_zpx
      |=> eff_addr == {`ZERO_PAGE_HI, 8'($past(opnd_lo) + $past(idx_x))}) // RL17
      else $error("zero page X address wrong");
   absx_carry_a: assert property (mode == flags_pkg::am_absx |=> eff_addr == 16'({$past(opnd_hi),
      $past(opnd_lo)} + {8'h00, $past(idx_x)}) && insn_len == `LEN_THREE) // RL22
      else $error("absolute X address wrong");
   push_order_a: assert property (irq_ack |=> push_hi_s($past(pc_in)) ##1 // RL21
      push_lo_ps_s($past(pc_in, 2)) ##1 idle) else $error("push order wrong");
   sp_step_a: assert property (stack_wr |=> sp == $past(sp) - 8'h01) // RL21
      else $error("stack pointer step");

endmodule

/* File: dv/bus_mem_model.sv */
// Purpose: memory at the far side of the flag block
// Assumes: pushes land on the rising edge while stack_wr is high
// Notes: unwritten bytes read as an address pattern
module bus_mem_model (
   input wire logic ref_clk,
   input wire logic [15:0] stack_addr,
   input wire logic [7:0] stack_wdata,
   input wire logic stack_wr,
   input wire logic [15:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic [7:0] x_idx,
   output logic [7:0] x_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [logic [15:0]];

   // sparse storage, so a stale byte never looks like a fresh one
   function automatic logic [7:0] peek(input logic [15:0] a);
      return mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8] ^ 8'h3c);
   endfunction

   // capture pushes
   always @(posedge ref_clk) begin
      if (stack_wr === 1'b1) mem[stack_addr] = stack_wdata;
   end

   // operand fetch port and page-zero X port
   always @* begin
      rd_data = peek(rd_addr);
      x_data = peek({8'h00, x_idx});
   end
endmodule

/* File: dv/tb_status_flags_and_address_gen.sv */
// Purpose: self-checking bench for the flag and address block
// Assumes: clk_en high except in one freeze check
// Notes: each scenario judges itself
`include "flags_params.svh"

module tb_status_flags_and_address_gen;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, sys_rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, cmd_valid = 0;
   logic irq_req = 0, irq_ack, busy, mode_ok, result_to_mem, stack_wr;
   logic [1:0] reg_addr = 0, insn_len;
   logic [7:0] reg_wdata = 0, opnd_lo = 0, opnd_hi = 0, idx_x = 0, idx_y = 0, acc = 0;
   logic [7:0] reg_rdata, mem_rdata, xmem_rdata, operand_data, result, stack_wdata, flags;
   logic [15:0] pc_in = 0, rd_addr = 0, eff_addr, result_addr, stack_addr;
   flags_pkg::flag_cmd_t cmd = flags_pkg::cmd_none;
   flags_pkg::addr_mode_t mode = flags_pkg::am_imm;
   int n_errors = 0, n_tests = 0;
   wire [11:0] nvzc = {result, flags[7:6], flags[1:0]}; // N V Z C beside result

   always #20 ref_clk = ~ref_clk;

   status_flags_and_address_gen dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd(cmd), .mode(mode),
      .opnd_lo(opnd_lo), .opnd_hi(opnd_hi), .idx_x(idx_x), .idx_y(idx_y), .acc(acc),
      .mem_rdata(mem_rdata), .xmem_rdata(xmem_rdata), .pc_in(pc_in), .irq_req(irq_req),
      .irq_ack(irq_ack), .busy(busy), .eff_addr(eff_addr), .operand_data(operand_data),
      .insn_len(insn_len), .mode_ok(mode_ok), .result(result), .result_to_mem(result_to_mem),
      .result_addr(result_addr), .stack_addr(stack_addr), .stack_wdata(stack_wdata),
      .stack_wr(stack_wr), .flags(flags));
   bus_mem_model partner (.ref_clk(ref_clk), .stack_addr(stack_addr),
      .stack_wdata(stack_wdata), .stack_wr(stack_wr), .rd_addr(rd_addr),
      .rd_data(mem_rdata), .x_idx(idx_x), .x_data(xmem_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   // shared helpers
   task results();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one-cycle command strobe, flags judged once the edge has landed
   task do_cmd(input flags_pkg::flag_cmd_t c,
               input flags_pkg::addr_mode_t m = flags_pkg::am_imm,
               input logic [7:0] a = 8'h00, input logic [7:0] op = 8'h00);
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd <= c;
      mode <= m;
      acc <= a;
      opnd_lo <= op;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      #1;
   endtask
   task reg_read(input logic [1:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task reg_write(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // bounded wait, a hang is a mismatch
   task automatic wait_idle();
      int i = 0;
      while (busy !== 1'b0) begin
         if (i++ == 20) begin
            n_errors++;
            results();
         end
         @(posedge ref_clk);
         #1;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task test_reset();
      logic [7:0] d;
      reg_read(`REG_FL, d);
      chk(d[`FLAG_I], 1'b1);
      reg_write(`REG_FL, 8'hc1);
      reg_read(`REG_FL, d);
      chk(d, 8'hc1);
      $display("reset test done");
   endtask
   task test_flag_cmds();
      int b [9] = '{0, 0, 2, 2, 3, 3, 5, 5, 6};
      // codes 1 to 8 are set/clear pairs in package order, 9 clears overflow
      for (int i = 1; i < 10; i++) begin
         do_cmd(flags_pkg::flag_cmd_t'(i));
         chk(flags[b[i - 1]], i[0] && i < 9);
      end
      clk_en <= 1'b0;
      do_cmd(flags_pkg::carry_set_insn);
      clk_en <= 1'b1;
      chk(flags[`FLAG_C], 1'b0);
      $display("flag command test done");
   endtask
   task test_binary();
      do_cmd(flags_pkg::cmd_add_carry, flags_pkg::am_imm, 8'hff, 8'h01);
      chk(nvzc, {8'h00, 4'b0011});
      do_cmd(flags_pkg::cmd_add_carry, flags_pkg::am_imm, 8'h7f, 8'h01);
      chk(nvzc, {8'h81, 4'b1100});
      do_cmd(flags_pkg::carry_set_insn);
      do_cmd(flags_pkg::subtract_borrow_insn, flags_pkg::am_imm, 8'h05, 8'h05);
      chk(nvzc, {8'h00, 4'b0111});
      do_cmd(flags_pkg::cmd_shift_left, flags_pkg::am_acc, 8'h88);
      chk(nvzc, {8'h10, 4'b0101});
      $display("binary arithmetic test done");
   endtask
   task test_decimal();
      do_cmd(flags_pkg::decimal_on_insn);
      do_cmd(flags_pkg::carry_clear_insn);
      do_cmd(flags_pkg::cmd_add_carry, flags_pkg::am_imm, 8'h09, 8'h01);
      chk({result, flags[0]}, {8'h10, 1'b0});
      do_cmd(flags_pkg::carry_set_insn);
      do_cmd(flags_pkg::subtract_borrow_insn, flags_pkg::am_imm, 8'h10, 8'h01);
      chk({result, flags[0]}, {8'h09, 1'b1});
      do_cmd(flags_pkg::cmd_transfer, flags_pkg::am_imm, 8'h00, 8'h9a);
      chk({result, flags[7], flags[1]}, {8'h9a, 2'b10});
      do_cmd(flags_pkg::binary_mode_insn);
      $display("decimal test done");
   endtask
   task test_bit();
      do_cmd(flags_pkg::overflow_clear_insn);
      do_cmd(flags_pkg::cmd_bit_test, flags_pkg::am_imm, 8'hff, 8'hbf);
      chk({flags[7:6], flags[1]}, 3'b100);
      do_cmd(flags_pkg::cmd_bit_test, flags_pkg::am_imm, 8'h00, 8'h40);
      chk({flags[6], flags[1]}, 2'b11);
      $display("bit test done");
   endtask
   // left operand is the page-zero byte at X: 20 ^ 3c = 1c
   task test_mem_mode();
      @(posedge ref_clk);
      idx_x <= 8'h20;
      do_cmd(flags_pkg::memory_mode_insn);
      do_cmd(flags_pkg::carry_clear_insn);
      do_cmd(flags_pkg::cmd_add_carry, flags_pkg::am_imm, 8'h55, 8'h03);
      chk({result, result_to_mem}, {8'h1f, 1'b1});
      chk(result_addr, 16'h0020);
      do_cmd(flags_pkg::accumulator_mode_insn);
      $display("memory mode test done");
   endtask
   task test_modes();
      flags_pkg::addr_mode_t m [7] = '{flags_pkg::am_imm, flags_pkg::am_acc, flags_pkg::am_zp,
         flags_pkg::am_zpx, flags_pkg::am_zpy, flags_pkg::am_abs, flags_pkg::am_absx};
      logic [7:0] lo [7] = '{8'ha7, 8'h00, 8'h80, 8'hf0, 8'hf0, 8'h34, 8'hff};
      logic [7:0] hi [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h12, 8'h12};
      logic [15:0] ea [7] = '{16'h0000, 16'h0000, 16'h0080, 16'h0010, 16'h0020, 16'h1234,
         16'h131f};
      logic [1:0] ln [7] = '{2'h2, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3};
      logic [7:0] d;
      idx_y <= 8'h30;
      for (int i = 0; i < 7; i++) begin
         @(posedge ref_clk);
         mode <= m[i];
         opnd_lo <= lo[i];
         opnd_hi <= hi[i];
         acc <= 8'h5c;
         rd_addr <= ea[i];
         d = (i == 0) ? lo[0] : (i == 1) ? 8'h5c : (ea[i][7:0] ^ ea[i][15:8] ^ 8'h3c);
         @(posedge ref_clk);
         #1;
         chk({operand_data, insn_len, mode_ok}, {d, ln[i], 1'b1});
         if (i > 1) chk(eff_addr, ea[i]);
      end
      @(posedge ref_clk);
      mode <= flags_pkg::am_implied;
      @(posedge ref_clk);
      #1;
      chk(mode_ok, 1'b0);
      $display("addressing test done");
   endtask
   task test_irq();
      logic [7:0] d;
      do_cmd(flags_pkg::interrupt_enable_insn);
      irq_req <= 1'b1;
      pc_in <= 16'hbeef;
      #1 chk(irq_ack, 1'b1);
      @(posedge ref_clk);
      irq_req <= 1'b0;
      #1 chk(flags[`FLAG_I], 1'b1);
      wait_idle();
      chk({partner.peek(16'h01ff), partner.peek(16'h01fe)}, 16'hbeef);
      d = partner.peek(16'h01fd);
      chk(d[`FLAG_B], 1'b0);
      reg_read(`REG_SP, d);
      chk(d, 8'hfc);
      @(posedge ref_clk);
      irq_req <= 1'b1;
      #1 chk(irq_ack, 1'b0);
      @(posedge ref_clk);
      irq_req <= 1'b0;
      do_cmd(flags_pkg::software_break_insn);
      wait_idle();
      chk({partner.peek(16'h01fc), partner.peek(16'h01fb)}, 16'hbeef);
      d = partner.peek(16'h01fa);
      chk(d[`FLAG_B], 1'b1);
      $display("interrupt test done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      test_reset();
      test_flag_cmds();
      test_binary();
      test_decimal();
      test_bit();
      test_mem_mode();
      test_modes();
      test_irq();
      results();
   end
endmodule
